// *** hdl/fsss_pkg.sv ***
// Purpose: constants for the field set speed supervisor
// Assumes: 100 MHz system clock, 32-bit AHB-Lite register bus
// Notes: register offsets are byte addresses
package fsss_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DELAY = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 3;

  // ctrl fields
  localparam int CTRL_AUTO_RESTART = 0;
  localparam int CTRL_AUTO_MODE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status fields
  localparam int STAT_SET_SEL = 0;
  localparam int STAT_SPEED = 1;
  localparam int STAT_STOP = 2;
  localparam int STAT_FENCE = 3;
  localparam int STAT_SAFE = 4;
  localparam int STAT_ESTOP = 5;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_IN_LSB = 16;

  // ---------------------------------------------------------------
  // bus encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned DWELL_TIME_MS = 500;
  localparam int unsigned DWELL_CYCLES =
    DWELL_TIME_MS * (CLOCK_HZ / 1000);
  localparam logic [31:0] DELAY_RESET = 32'h0000_03e8;

  // ---------------------------------------------------------------
  // field set select encoding and input vector layout
  // ---------------------------------------------------------------
  localparam logic SET_ONE = 1'h0;
  localparam logic SET_TWO = 1'h1;
  localparam int NUM_IN = 8;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_STOP,
    ST_DWELL,
    ST_WAIT_MAN,
    ST_SEQ_ERR,
    ST_SAFE
  } fsss_state_e;

endpackage

// *** hdl/fsss_sync.sv ***
// Purpose: two flip-flop synchroniser for a vector of pins
// Assumes: each bit is an independent level
// Notes: first stage read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module fsss_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      meta_q <= INIT;
      o_q <= INIT;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// *** hdl/fsss_timer.sv ***
// Purpose: loadable down counter with a done level
// Assumes: load and clear are single-cycle or levels
// Notes: clear wins over load; done holds until next load or clear
`timescale 1ns/1ps
`default_nettype none
module fsss_timer #(
  parameter int WIDTH = 32
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic i_clear,
  input wire logic [WIDTH-1:0] i_value,
  output logic o_done
);

  logic [WIDTH-1:0] cnt_q;
  logic run_q;
  wire logic expire = run_q && (cnt_q <= WIDTH'(1));

  always_ff @(posedge i_clock) begin
    if (!i_rstn || i_clear) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      o_done <= 1'b0;
    end else if (i_load) begin
      cnt_q <= i_value;
      run_q <= 1'b1;
      o_done <= 1'b0;
    end else if (expire) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      o_done <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q - WIDTH'(1);
    end
  end

endmodule
`default_nettype wire

// *** hdl/fsss_top.sv ***
// Purpose: field set and speed supervisor with AHB-Lite registers
// Assumes: scanner and pushbutton pins are asynchronous
// Notes: all outputs come straight from flip-flops
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fsss_top #(
  parameter int unsigned DWELL_CYC = fsss_pkg::DWELL_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  // scanner and operator pins, all active high
  input wire logic i_warn_infringed,
  input wire logic i_prot_infringed,
  input wire logic i_estop_pressed,
  input wire logic i_reset_button,
  input wire logic i_manual_restart,
  input wire logic i_link_ok,
  input wire logic i_supply_ok,
  input wire logic i_internal_fault,
  // to scanner and robot controller
  output logic o_set_select,
  output logic o_speed_reduce_a,
  output logic o_speed_reduce_b,
  output logic o_stop_request,
  output logic o_safeguarding_fence_stop,
  output logic o_safe_state,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  localparam int NI = fsss_pkg::NUM_IN;
  logic [NI-1:0] pins;
  logic [NI-1:0] sync;
  logic [NI-1:0] sync_prev_q;

  assign pins = {i_internal_fault, i_supply_ok, i_link_ok,
                 i_manual_restart, i_reset_button, i_estop_pressed,
                 i_prot_infringed, i_warn_infringed};

  // link and supply start as lost, so a missed pin reads as a fault
  fsss_sync #(
    .WIDTH(NI),
    .INIT(8'h00)
  ) u_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_d(pins),
    .o_q(sync)
  );

  wire logic warn = sync[0];
  wire logic prot = sync[1];
  wire logic estop = sync[2];
  wire logic rst_btn_rise = sync[3] && !sync_prev_q[3];
  wire logic man_rise = sync[4] && !sync_prev_q[4];
  wire logic fault = !sync[5] || !sync[6] || sync[7];

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      sync_prev_q <= '0;
    end else begin
      sync_prev_q <= sync;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [31:0] delay_q;
  logic wr_pend_q;
  logic [3:0] wr_addr_q;
  logic [31:0] status;
  logic [31:0] rdata;

  wire logic addr_ph = i_hsel && i_hready &&
                       (i_htrans == fsss_pkg::HTRANS_NONSEQ) &&
                       (i_hsize == fsss_pkg::HSIZE_WORD);
  wire logic [3:0] a_off = {i_haddr[fsss_pkg::ADDR_MSB:fsss_pkg::ADDR_LSB],
                            2'h0};
  wire logic a_mapped = (i_haddr[31:fsss_pkg::ADDR_MSB+1] == '0);
  wire logic wr_ctrl = wr_pend_q && (wr_addr_q == fsss_pkg::ADDR_CTRL);
  wire logic wr_delay = wr_pend_q && (wr_addr_q == fsss_pkg::ADDR_DELAY);

  assign rdata = !a_mapped ? 32'h0000_0000 :
                 (a_off == fsss_pkg::ADDR_CTRL) ? {30'h0, ctrl_q} :
                 (a_off == fsss_pkg::ADDR_DELAY) ? delay_q :
                 (a_off == fsss_pkg::ADDR_STATUS) ? status :
                 32'h0000_0000;

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      o_hrdata <= '0;
      o_hreadyout <= 1'b1;
      o_hresp <= fsss_pkg::HRESP_OKAY;
    end else begin
      wr_pend_q <= addr_ph && i_hwrite && a_mapped;
      wr_addr_q <= a_off;
      o_hreadyout <= 1'b1;
      o_hresp <= fsss_pkg::HRESP_OKAY;
      if (addr_ph && !i_hwrite) begin
        o_hrdata <= rdata;
      end
    end
  end

  // configuration written by software
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ctrl_q <= fsss_pkg::CTRL_RESET;
      delay_q <= fsss_pkg::DELAY_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_hwdata[1:0];
      end
      if (wr_delay) begin
        delay_q <= i_hwdata;
      end
    end
  end

  wire logic auto_restart = ctrl_q[fsss_pkg::CTRL_AUTO_RESTART];
  wire logic auto_mode = ctrl_q[fsss_pkg::CTRL_AUTO_MODE];

  // ---------------------------------------------------------------
  // stop and restart sequencer
  // ---------------------------------------------------------------
  fsss_pkg::fsss_state_e state_q;
  fsss_pkg::fsss_state_e state_d;
  logic dwell_done;
  logic estop_q;

  wire logic enter_dwell = (state_q == fsss_pkg::ST_STOP) &&
                           (state_d == fsss_pkg::ST_DWELL);

  // exit dwell: warning must stay infringed after protective clears
  fsss_timer #(
    .WIDTH(32)
  ) u_dwell (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_load(enter_dwell),
    .i_clear(state_q != fsss_pkg::ST_DWELL && !enter_dwell),
    .i_value(32'(DWELL_CYC)),
    .o_done(dwell_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      fsss_pkg::ST_RUN: begin
        if (prot) begin
          state_d = fsss_pkg::ST_STOP;
        end
      end
      fsss_pkg::ST_STOP: begin
        if (!prot) begin
          state_d = auto_restart ? fsss_pkg::ST_DWELL
                                 : fsss_pkg::ST_WAIT_MAN;
        end
      end
      fsss_pkg::ST_DWELL: begin
        if (prot) begin
          state_d = fsss_pkg::ST_STOP;
        end else if (!warn) begin
          state_d = auto_mode ? fsss_pkg::ST_SEQ_ERR
                              : fsss_pkg::ST_WAIT_MAN;
        end else if (dwell_done) begin
          state_d = fsss_pkg::ST_RUN;
        end
      end
      fsss_pkg::ST_WAIT_MAN: begin
        if (prot) begin
          state_d = fsss_pkg::ST_STOP;
        end else if (man_rise) begin
          state_d = fsss_pkg::ST_RUN;
        end
      end
      fsss_pkg::ST_SEQ_ERR: begin
        if (rst_btn_rise && !prot) begin
          state_d = fsss_pkg::ST_WAIT_MAN;
        end
      end
      fsss_pkg::ST_SAFE: begin
        if (!fault && rst_btn_rise) begin
          state_d = fsss_pkg::ST_WAIT_MAN;
        end
      end
      default: begin
        state_d = fsss_pkg::ST_SAFE;
      end
    endcase
    if (fault) begin
      state_d = fsss_pkg::ST_SAFE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_q <= fsss_pkg::ST_WAIT_MAN;
    end else begin
      state_q <= state_d;
    end
  end

  // emergency stop latched until released and reset button pressed
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      estop_q <= 1'b0;
    end else if (estop) begin
      estop_q <= 1'b1;
    end else if (rst_btn_rise) begin
      estop_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // reduced speed and field set selection
  // ---------------------------------------------------------------
  logic speed_q;
  logic switch_done;
  logic set_q;

  wire logic safe_d = (state_d == fsss_pkg::ST_SAFE);
  // held while either field is infringed
  wire logic speed_d = warn || prot || safe_d;
  wire logic speed_rise = speed_d && !speed_q;

  fsss_timer #(
    .WIDTH(32)
  ) u_switch (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_load(speed_rise),
    .i_clear(!speed_q && !speed_rise),
    .i_value(delay_q),
    .o_done(switch_done)
  );

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      speed_q <= 1'b0;
      set_q <= fsss_pkg::SET_ONE;
    end else begin
      speed_q <= speed_d;
      if (!speed_d) begin
        set_q <= fsss_pkg::SET_ONE;
      end else if (switch_done && speed_q) begin
        set_q <= fsss_pkg::SET_TWO;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_set_select <= fsss_pkg::SET_ONE;
      o_speed_reduce_a <= 1'b0;
      o_speed_reduce_b <= 1'b0;
      o_stop_request <= 1'b1;
      o_safeguarding_fence_stop <= 1'b0;
      o_safe_state <= 1'b0;
    end else begin
      o_set_select <= set_q;
      o_speed_reduce_a <= speed_q;
      o_speed_reduce_b <= speed_q;
      o_stop_request <= (state_q != fsss_pkg::ST_RUN) || estop_q;
      o_safeguarding_fence_stop <= (state_q == fsss_pkg::ST_SEQ_ERR);
      o_safe_state <= (state_q == fsss_pkg::ST_SAFE);
    end
  end

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  assign status = {8'h00, sync,
                   5'h00, 3'(state_q),
                   2'h0, estop_q, o_safe_state,
                   o_safeguarding_fence_stop, o_stop_request,
                   speed_q, set_q};

endmodule
`default_nettype wire

// *** tb/fsss_assertions.sv ***
// Purpose: pin-level checks on the supervisor
// Assumes: bound into fsss_top
// Notes: pin changes reach outputs about four edges later
`timescale 1ns/1ps
`default_nettype none
module fsss_assertions #(
  parameter int unsigned DWELL_CYC = 20
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_warn_infringed,
  input wire logic i_prot_infringed,
  input wire logic i_estop_pressed,
  input wire logic i_reset_button,
  input wire logic i_link_ok,
  input wire logic o_set_select,
  input wire logic o_speed_reduce_a,
  input wire logic o_speed_reduce_b,
  input wire logic o_stop_request,
  input wire logic o_safeguarding_fence_stop,
  input wire logic o_safe_state,
  input wire logic o_hreadyout,
  input wire logic o_hresp
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  sequence s_all_clear;
    (!i_warn_infringed && !i_prot_infringed && !o_safe_state) [*6];
  endsequence
  sequence s_fence_freed;
    $past(i_reset_button, 2) && o_stop_request;
  endsequence
  a_speed_dual: assert property (o_speed_reduce_a == o_speed_reduce_b)
    else $error("speed channels differ");
  a_warn_speed: assert property (i_warn_infringed [*6] |->
    o_speed_reduce_a)
    else $error("no reduced speed on warning");
  a_clear_full: assert property (s_all_clear |->
    !o_speed_reduce_a && !o_set_select)
    else $error("reduced speed with fields clear");
  a_prot_stop: assert property (i_prot_infringed [*5] |-> o_stop_request)
    else $error("no stop on protective field");
  a_estop_stop: assert property (i_estop_pressed [*5] |->
    o_stop_request)
    else $error("no stop on emergency stop");
  a_fault_safe: assert property ((!i_link_ok) [*6] |->
    o_safe_state && o_stop_request && o_speed_reduce_a)
    else $error("no safe state on link loss");
  a_set_two: assert property ($rose(o_set_select) |->
    o_speed_reduce_a && $past(o_speed_reduce_a, 2))
    else $error("set two without reduced speed");
  a_fence_stop: assert property (o_safeguarding_fence_stop |->
    o_stop_request)
    else $error("fence stop without stop");
  a_fence_free: assert property ($fell(o_safeguarding_fence_stop) |->
    s_fence_freed)
    else $error("fence stop left without button");
  a_reset_vals: assert property (disable iff (1'b0) !i_rstn |=>
    o_stop_request && !o_set_select && !o_speed_reduce_a && !o_safe_state)
    else $error("bad reset outputs");
  a_bus_okay: assert property (o_hreadyout && o_hresp == fsss_pkg::HRESP_OKAY)
    else $error("bus not ready or not okay");
endmodule
bind fsss_top fsss_assertions #(.DWELL_CYC(DWELL_CYC)) u_chk (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_warn_infringed(i_warn_infringed),
  .i_prot_infringed(i_prot_infringed), .i_estop_pressed(i_estop_pressed),
  .i_reset_button(i_reset_button), .i_link_ok(i_link_ok),
  .o_set_select(o_set_select), .o_speed_reduce_a(o_speed_reduce_a),
  .o_speed_reduce_b(o_speed_reduce_b), .o_stop_request(o_stop_request),
  .o_safeguarding_fence_stop(o_safeguarding_fence_stop),
  .o_safe_state(o_safe_state), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp)
);
`default_nettype wire

// *** tb/fsss_far_side.sv ***
// Purpose: scanner fields and robot controller model
// Assumes: person position given as a zone code
// Notes: warning field is the same in both sets
`timescale 1ns/1ps
`default_nettype none
module fsss_far_side (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [1:0] i_zone,
  input wire logic i_speed_a,
  input wire logic i_speed_b,
  input wire logic i_set_select,
  input wire logic [31:0] i_delay,
  output logic o_warn,
  output logic o_prot,
  output logic o_early
);
  logic [31:0] slow_cnt_q;
  // zone 1 warning only, zone 2 protective too
  assign o_warn = i_zone != 2'h0;
  assign o_prot = i_zone == 2'h2;
  // robot keeps its own copy of the switch delay
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      slow_cnt_q <= 32'h0;
      o_early <= 1'b0;
    end else begin
      slow_cnt_q <= (i_speed_a && i_speed_b) ? slow_cnt_q + 32'h1 : 32'h0;
      if (i_set_select && slow_cnt_q + 32'h2 < i_delay)
        o_early <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_field_set_speed_supervisor.sv ***
// Purpose: self-checking bench for the supervisor
// Assumes: short dwell, random switch delay
// Notes: outs packs stop, fence, safe, set, speed a, speed b
`timescale 1ns/1ps
`default_nettype none
module test_field_set_speed_supervisor;
  localparam int unsigned DW = 20;
  logic i_clock, i_rstn, estop, rbtn, man, hsel, hwrite, hr, hresp;
  logic warn, prot, early, set_sel, spd_a, spd_b, stop, fence, safe;
  logic [1:0] zone, htrans;
  logic [2:0] hsize, flt;
  logic [31:0] haddr, hwdata, hrdata, rd, dly;
  wire [5:0] outs = {stop, fence, safe, set_sel, spd_a, spd_b};
  int failures, n_tests, cyc;
  fsss_top #(.DWELL_CYC(DW)) dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_warn_infringed(warn),
    .i_prot_infringed(prot), .i_estop_pressed(estop), .i_reset_button(rbtn),
    .i_manual_restart(man), .i_link_ok(!flt[0]), .i_supply_ok(!flt[1]),
    .i_internal_fault(flt[2]), .o_set_select(set_sel),
    .o_speed_reduce_a(spd_a), .o_speed_reduce_b(spd_b),
    .o_stop_request(stop), .o_safeguarding_fence_stop(fence),
    .o_safe_state(safe), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hr),
    .o_hreadyout(hr), .o_hresp(hresp), .o_hrdata(hrdata));
  fsss_far_side far (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_zone(zone), .i_speed_a(spd_a),
    .i_speed_b(spd_b), .i_set_select(set_sel), .i_delay(dly),
    .o_warn(warn), .o_prot(prot), .o_early(early));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] ctrl_rb(input logic [31:0] w);
    return w & 32'h3;
  endfunction
  function automatic int settle(input logic [31:0] d);
    return int'(d) + 8;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    hwrite <= w;
    htrans <= fsss_pkg::HTRANS_NONSEQ;
    do @(posedge i_clock); while (hr !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clock); while (hr !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic press(input logic r, input logic m);
    rbtn <= r;
    man <= m;
    tick(10);
    rbtn <= 1'b0;
    man <= 1'b0;
    tick(10);
  endtask
  task automatic go(input logic [1:0] z, input int n);
    zone <= z;
    tick(n);
  endtask
  // wrong exit: warning left before the dwell ends
  task automatic bad_exit;
    go(2'h1, settle(dly));
    go(2'h2, 8);
    go(2'h1, 3);
    go(2'h0, DW + 8);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, timeout, sequence
  // ---------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    rd = $urandom(32'h7122);
    {i_rstn, estop, rbtn, man, hsel, hwrite, zone, htrans, flt} = '0;
    {haddr, hwdata, failures, n_tests} = '0;
    hsize = fsss_pkg::HSIZE_WORD;
    dly = 32'h6 + ($urandom % 10);
    tick(6);
    chk(32'(outs), 32'h20);
    chk(32'({hr, hresp}), 32'h2);
    i_rstn <= 1'b1;
    bus(1'b0, fsss_pkg::ADDR_DELAY, 32'h0);
    chk(rd, fsss_pkg::DELAY_RESET);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, fsss_pkg::ADDR_DELAY, dly);
    bus(1'b1, fsss_pkg::ADDR_CTRL, 32'hff);
    bus(1'b0, fsss_pkg::ADDR_DELAY, 32'h0);
    chk(rd, dly);
    bus(1'b0, fsss_pkg::ADDR_CTRL, 32'h0);
    chk(rd, ctrl_rb(32'hff));
    press(1'b1, 1'b0);
    press(1'b0, 1'b1);
    chk(32'(outs), 32'h0);
    // status in run: supply and link good, nothing else set
    bus(1'b0, fsss_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0060_0000);
    go(2'h1, 5);
    chk(32'(outs), 32'h3);
    go(2'h1, settle(dly) + ($urandom % 5));
    chk(32'(outs), 32'h7);
    go(2'h2, 8);
    chk(32'(outs), 32'h27);
    go(2'h1, 8);
    chk(32'(outs), 32'h27);
    tick(DW);
    chk(32'(outs), 32'h7);
    go(2'h0, 8);
    chk(32'(outs), 32'h0);
    chk(32'(early), 32'h0);
    bad_exit();
    chk(32'(outs), 32'h30);
    // status in sequence error: stop, fence, state code 4
    bus(1'b0, fsss_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0060_040c);
    press(1'b1, 1'b0);
    chk(32'(outs), 32'h20);
    press(1'b0, 1'b1);
    for (int c = 1; c >= 0; c--) begin
      bus(1'b1, fsss_pkg::ADDR_CTRL, 32'(c));
      bad_exit();
      chk(32'(outs), 32'h20);
      press(1'b0, 1'b1);
      chk(32'(outs), 32'h0);
    end
    estop <= 1'b1;
    tick(8);
    chk(32'(outs), 32'h20);
    estop <= 1'b0;
    tick(8);
    chk(32'(outs), 32'h20);
    press(1'b1, 1'b0);
    chk(32'(outs), 32'h0);
    for (int i = 0; i < 3; i++) begin
      flt <= 3'h1 << i;
      tick(8);
      chk(32'(outs), 32'h2b);
      flt <= 3'h0;
      press(1'b1, 1'b0);
      press(1'b0, 1'b1);
      chk(32'(outs), 32'h0);
    end
    // mid-run reset: safe start, set one, delay back to default
    i_rstn <= 1'b0;
    tick(2);
    i_rstn <= 1'b1;
    tick(4);
    chk(32'(outs), 32'h2b);
    bus(1'b0, fsss_pkg::ADDR_DELAY, 32'h0);
    chk(rd, fsss_pkg::DELAY_RESET);
    give_verdict();
  end
endmodule
`default_nettype wire
